// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic reg_write = 1'b0, reg_read = 1'b0, reg_rvalid, run = 1'b0;
  logic quad_reset_pin = 1'b0, serdes_reset_pin = 1'b0;
  logic tx_reset_pin = 1'b0, rx_reset_pin = 1'b0;
  logic [3:0] tx_clk;
  logic [7:0] codes [5] = '{8'h07, 8'hFB, 8'hFD, 8'h9C, 8'hFE};
  logic [7:0] ofs [8] = '{8'h13, 8'h19, 8'h28, 8'h30, 8'h40, 8'h41, 8'h42, 8'h43};
  logic [7:0] dflt [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h80, 8'h00};
  xaui_quad_pkg::lane_s [3:0] tx_lane, w, word = '0;
  xaui_quad_pkg::resets_s resets;
  xaui_quad_pkg::config_s config_out;
  xaui_quad_pkg::group_s [3:0] tx_group;
  int err_total = 0, checked = 0, cycles = 0, seed = 42;
  xaui_quad_reset_and_tx_port #(.LANES(4)) i_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .quad_reset_pin(quad_reset_pin),
    .serdes_reset_pin(serdes_reset_pin), .tx_reset_pin(tx_reset_pin),
    .rx_reset_pin(rx_reset_pin), .tx_clk(tx_clk), .tx_lane(tx_lane),
    .resets(resets), .config_out(config_out), .tx_group(tx_group)
  );
  xgmii_fabric_model i_fabric (.run(run), .word(word), .tx_clk(tx_clk), .tx_lane(tx_lane));
  // core clock and hang guard
  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_total++;
      complete_run();
    end
  end
  task check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task complete_run;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task rchk(input logic [7:0] a, exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    // the answer stands for one cycle from this edge; look mid-cycle
    @(negedge clock);
    check("read answer", reg_rvalid, 1'b1);
    check("register", reg_rdata, exp);
  endtask : rchk
  task pause;
    repeat (6) @(posedge clock);
  endtask : pause
  // code-group kind expected for one byte and its flag
  function xaui_quad_pkg::kind_e kind_of(input logic [7:0] b, input logic c);
    if (!c) return xaui_quad_pkg::KIND_DATA;
    case (b)
      8'h07: return xaui_quad_pkg::KIND_IDLE;
      8'hFB: return xaui_quad_pkg::KIND_START;
      8'hFD: return xaui_quad_pkg::KIND_TERM;
      8'h9C: return xaui_quad_pkg::KIND_SEQ;
      default: return xaui_quad_pkg::KIND_ERROR;
    endcase
  endfunction : kind_of
  // skip the word in flight, then judge the next one on every lane
  task send(input logic wide);
    int n;
    repeat (2)
    begin
      n = 0;
      @(negedge clock);
      while (tx_group[0].valid !== 1'b1 && n < 40)
      begin
        @(negedge clock);
        n++;
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      check("lane valid", tx_group[i].valid, 1'b1);
      check("lane data", tx_group[i].data,
        wide ? word[i].data : {8'h00, word[i].data[7:0]});
      check("low kind", tx_group[i].kind_lo, kind_of(word[i].data[7:0], word[i].ctrl[0]));
      check("high kind", tx_group[i].kind_hi, wide ? kind_of(word[i].data[15:8],
        word[i].ctrl[1]) : xaui_quad_pkg::KIND_NONE);
    end
  endtask : send
  // main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    run <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(ofs[i], dflt[i]);
    rchk(8'h55, 8'h00);
    $display("defaults done");
    repeat (6)
    begin
      v = 8'($random(seed));
      wr(8'h13, v);
      rchk(8'h13, v);
      check("tx rate", config_out.full_rate_tx, !v[5]);
      check("rx rate", config_out.full_rate_rx, !v[4]);
      wr(8'h28, v);
      rchk(8'h28, v);
      check("refclk mode", config_out.refclk_mode, {v[3], v[2]});
      wr(8'h19, v);
      rchk(8'h19, v);
      check("width", {config_out.tx_wide, config_out.rx_wide}, {v[4], v[5]});
    end
    wr(8'h30, 8'h20);
    wr(8'h41, 8'h00);
    rchk(8'h41, 8'h00);
    check("tx sync", config_out.tx_sync, 1'b1);
    check("serializer reset", resets.serdes, 1'b0);
    wr(8'h40, 8'h8B);
    pause();
    check("tx lane reset", resets.tx_lane, 4'h1);
    check("rx lane reset", resets.rx_lane, 4'hD);
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h20);
    pause();
    check("serializer bit", {resets.serdes, resets.quad, resets.tx_lane}, 6'h20);
    wr(8'h41, 8'h00);
    $display("registers done");
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h19, m ? 8'h10 : 8'h00);
      for (int k = 0; k < 14; k++)
      begin
        w = 72'({$random(seed), $random(seed), $random(seed)});
        for (int j = 0; j < 4; j++)
        begin
          if (k < 5) w[j].data = {codes[(k + j) % 5], codes[k]};
          if (k < 5) w[j].ctrl = 2'h3;
        end
        word <= w;
        send(m[0]);
      end
    end
    $display("lanes done");
    @(posedge clock);
    tx_reset_pin <= 1'b1;
    rx_reset_pin <= 1'b1;
    serdes_reset_pin <= 1'b1;
    pause();
    check("tx pin", resets.tx_lane, 4'hF);
    check("rx pin", resets.rx_lane, 4'hF);
    check("serdes pin", {resets.serdes, resets.quad}, 2'h2);
    tx_reset_pin <= 1'b0;
    rx_reset_pin <= 1'b0;
    serdes_reset_pin <= 1'b0;
    quad_reset_pin <= 1'b1;
    pause();
    check("quad pin", resets.quad, 1'b1);
    quad_reset_pin <= 1'b0;
    pause();
    rchk(8'h30, 8'h00);
    rchk(8'h41, 8'h20);
    wr(8'h42, 8'h00);
    wr(8'h30, 8'h20);
    quad_reset_pin <= 1'b1;
    pause();
    check("gated pin", resets.quad, 1'b0);
    quad_reset_pin <= 1'b0;
    rchk(8'h30, 8'h20);
    wr(8'h43, 8'h80);
    pause();
    rchk(8'h42, 8'h80);
    rchk(8'h43, 8'h00);
    $display("resets done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire

// ---- xaui_quad_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module xaui_quad_checker #(
  parameter int LANES = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_rvalid,
  input wire xaui_quad_pkg::resets_s resets,
  input wire xaui_quad_pkg::config_s config_out,
  input wire xaui_quad_pkg::group_s [LANES-1:0] tx_group
);
  // all checks on the core clock, quiet in reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // accepted writes to the reset registers
  wire wr_quad = reg_write && reg_addr == 8'h43 && !resets.quad;
  wire wr_ser = reg_write && reg_addr == 8'h41 && !resets.quad;
  wire wr_lane = reg_write && reg_addr == 8'h40 && !resets.quad;
  chk_read_answer: assert property (reg_read |=> reg_rvalid)
    else $error("read strobe got no answer");
  chk_rvalid_lone: assert property (!reg_read |=> !reg_rvalid)
    else $error("answer without read");
  chk_quad_soft: assert property (wr_quad && reg_wdata[7] |-> ##2 resets.quad)
    else $error("quad reset bit ignored");
  chk_quad_defaults: assert property ($rose(resets.quad) |-> ##[0:3] config_out == 7'h60)
    else $error("config not back to defaults");
  chk_serdes_soft: assert property (wr_ser && reg_wdata[5] |-> ##[1:2] resets.serdes)
    else $error("serializer reset bit ignored");
  chk_tx_map: assert property (wr_lane && reg_wdata[7] |-> ##[1:2] resets.tx_lane[0])
    else $error("tx lane 0 reset bit misplaced");
  chk_rx_map: assert property (wr_lane && reg_wdata[3] |-> ##[1:2] resets.rx_lane[0])
    else $error("rx lane 0 reset bit misplaced");
  chk_quiet_lane: assert property (resets.tx_lane[0] && $past(resets.tx_lane[0])
    |-> !tx_group[0].valid)
    else $error("lane in reset produced a word");
  chk_valid_pulse: assert property (tx_group[0].valid |=> !tx_group[0].valid)
    else $error("lane word valid too long");
  chk_narrow_pair: assert property (tx_group[0].valid && !config_out.tx_wide
    |-> tx_group[0].kind_hi == xaui_quad_pkg::KIND_NONE && tx_group[0].data[15:8] == 8'h00)
    else $error("narrow lane carries a high byte");
endmodule : xaui_quad_checker
bind xaui_quad_reset_and_tx_port xaui_quad_checker #(.LANES(LANES)) i_checker (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rvalid(reg_rvalid),
  .resets(resets), .config_out(config_out), .tx_group(tx_group)
);
`default_nettype wire

// ---- xaui_quad_pkg.sv ----
package xaui_quad_pkg;

  // register offsets
  localparam logic [7:0] OFS_RATE = 8'h13;
  localparam logic [7:0] OFS_WIDTH = 8'h19;
  localparam logic [7:0] OFS_REFCLK = 8'h28;
  localparam logic [7:0] OFS_SYNC = 8'h30;
  localparam logic [7:0] OFS_LANE_RST = 8'h40;
  localparam logic [7:0] OFS_SER_RST = 8'h41;
  localparam logic [7:0] OFS_GATE = 8'h42;
  localparam logic [7:0] OFS_QUAD_RST = 8'h43;

  // reset values
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_WIDTH = 8'h00;
  localparam logic [7:0] RST_REFCLK = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [7:0] RST_LANE_RST = 8'h00;
  localparam logic [7:0] RST_SER_RST = 8'h20;
  localparam logic [7:0] RST_GATE = 8'h80;
  localparam logic [7:0] RST_QUAD_RST = 8'h00;

  // field positions
  localparam int BIT_RATE_TX = 5;
  localparam int BIT_RATE_RX = 4;
  localparam int BIT_WIDE_TX = 4;
  localparam int BIT_WIDE_RX = 5;
  localparam int BIT_REFCLK_HI = 3;
  localparam int BIT_REFCLK_LO = 2;
  localparam int BIT_TX_SYNC = 5;
  localparam int BIT_TX_LANE_TOP = 7;
  localparam int BIT_RX_LANE_TOP = 3;
  localparam int BIT_SER_RST = 5;
  localparam int BIT_GATE = 7;
  localparam int BIT_QUAD_RST = 7;

  // reset pin positions inside the synchroniser vector
  localparam int PIN_QUAD = 0;
  localparam int PIN_SERDES = 1;
  localparam int PIN_TX = 2;
  localparam int PIN_RX = 3;

  // control character codes on the parallel lanes
  localparam logic [7:0] CHAR_IDLE = 8'h07;
  localparam logic [7:0] CHAR_START = 8'hFB;
  localparam logic [7:0] CHAR_TERM = 8'hFD;
  localparam logic [7:0] CHAR_SEQ = 8'h9C;
  localparam logic [7:0] CHAR_ERROR = 8'hFE;

  // reference clock mode codes
  localparam logic [1:0] REFCLK_156M25 = 2'h0;
  localparam logic [1:0] REFCLK_312M5 = 2'h1;
  localparam logic [1:0] REFCLK_625M = 2'h2;

  // kind of code-group chosen for one byte
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_DATA,
    KIND_IDLE,
    KIND_START,
    KIND_TERM,
    KIND_SEQ,
    KIND_ERROR
  } kind_e;

  // one lane as driven by the fabric
  typedef struct packed {
    logic [15:0] data;
    logic [1:0] ctrl;
  } lane_s;

  // one sampled lane handed to the encoder stage
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    kind_e kind_hi;
    kind_e kind_lo;
  } group_s;

  // reset levels towards the quad
  typedef struct packed {
    logic quad;
    logic serdes;
    logic [3:0] tx_lane;
    logic [3:0] rx_lane;
  } resets_s;

  // configuration levels towards the quad
  typedef struct packed {
    logic full_rate_tx;
    logic full_rate_rx;
    logic [1:0] refclk_mode;
    logic tx_wide;
    logic rx_wide;
    logic tx_sync;
  } config_s;

endpackage : xaui_quad_pkg

// ---- xaui_quad_reset_and_tx_port.sv ----
`timescale 1ns/1ps
`default_nettype none

module xaui_quad_reset_and_tx_port #(
  parameter int LANES = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic quad_reset_pin,
  input wire logic serdes_reset_pin,
  input wire logic tx_reset_pin,
  input wire logic rx_reset_pin,
  input wire logic [LANES-1:0] tx_clk,
  input wire xaui_quad_pkg::lane_s [LANES-1:0] tx_lane,
  output xaui_quad_pkg::resets_s resets,
  output xaui_quad_pkg::config_s config_out,
  output xaui_quad_pkg::group_s [LANES-1:0] tx_group
);

  // everything the block remembers
  // the eight registers come first, then the read answer,
  // then the synchroniser stages, then the output copies;
  // the outputs are taken straight from here, never from logic,
  // so every pin of the block is driven by a flop
  typedef struct packed {
    // register copies
    logic [7:0] rate;
    logic [7:0] width;
    logic [7:0] refclk;
    logic [7:0] sync;
    logic [7:0] lane_rst;
    logic [7:0] ser_rst;
    logic [7:0] gate;
    logic [7:0] quad_rst;
    // read answer
    logic [7:0] rdata;
    logic rvalid;
    // two-flop stages for the reset pins
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    // lane clock stages, the third keeps the level before the edge
    logic [LANES-1:0] clk_s1;
    logic [LANES-1:0] clk_s2;
    logic [LANES-1:0] clk_s3;
    // lane data stages, kept in step with the clock stages
    xaui_quad_pkg::lane_s [LANES-1:0] lane_s1;
    xaui_quad_pkg::lane_s [LANES-1:0] lane_s2;
    xaui_quad_pkg::lane_s [LANES-1:0] lane_s3;
    // output copies
    xaui_quad_pkg::resets_s resets;
    xaui_quad_pkg::config_s cfg;
    xaui_quad_pkg::group_s [LANES-1:0] group;
  } state_s;

  state_s state;
  state_s next_state;

  // picks the code-group kind for one byte and its flag
  // a flagged byte that is none of the known characters goes out
  // as an error group, so a fabric fault shows on the line
  function automatic xaui_quad_pkg::kind_e classify(
    input logic [7:0] byte_in,
    input logic ctrl_in
  );
    xaui_quad_pkg::kind_e kind;
    kind = xaui_quad_pkg::KIND_DATA;
    if (ctrl_in)
    begin
      case (byte_in)
        xaui_quad_pkg::CHAR_IDLE: kind = xaui_quad_pkg::KIND_IDLE;
        xaui_quad_pkg::CHAR_START: kind = xaui_quad_pkg::KIND_START;
        xaui_quad_pkg::CHAR_TERM: kind = xaui_quad_pkg::KIND_TERM;
        xaui_quad_pkg::CHAR_SEQ: kind = xaui_quad_pkg::KIND_SEQ;
        default: kind = xaui_quad_pkg::KIND_ERROR; // unknown control sent as error
      endcase
    end
    return kind;
  endfunction : classify

  // register defaults, shared by reset and by a quad reset
  // only the registers are touched here; the synchroniser stages
  // keep running, so a pin seen during a quad reset is not lost
  // and the lane stages carry no stale word past the reset
  function automatic state_s with_defaults(input state_s s);
    state_s d;
    d = s;
    d.rate = xaui_quad_pkg::RST_RATE;
    d.width = xaui_quad_pkg::RST_WIDTH;
    d.refclk = xaui_quad_pkg::RST_REFCLK;
    d.sync = xaui_quad_pkg::RST_SYNC;
    d.lane_rst = xaui_quad_pkg::RST_LANE_RST;
    d.ser_rst = xaui_quad_pkg::RST_SER_RST;
    d.gate = xaui_quad_pkg::RST_GATE;
    d.quad_rst = xaui_quad_pkg::RST_QUAD_RST;
    return d;
  endfunction : with_defaults

  // helper values of the next-state logic, written before read
  logic pins_on;
  logic quad_now;
  logic serdes_now;
  logic tx_all_now;
  logic rx_all_now;
  logic [LANES-1:0] rise;
  logic [LANES-1:0] take;
  logic wide;

  // next state of the whole block
  // the whole block is one struct: this process works out the next
  // copy and the clocked process below registers it
  // latencies: a register write shows one edge later, a derived
  // level one edge after that; a pin needs two sync edges and one
  // output edge; a lane word shows about three edges after its rise
  // the lane clock must stay below a third of the core clock
  always_comb
  begin
    next_state = state;
    next_state.rvalid = 1'b0;

    // reset pins pass two flops before use
    next_state.pin_s1 = {rx_reset_pin, tx_reset_pin, serdes_reset_pin, quad_reset_pin};
    next_state.pin_s2 = state.pin_s1;

    // pins count only while the gate bit is one
    // a register reset bit works even with the gate off, so software
    // can still recover a quad whose pins are stuck; a quad reset
    // also holds the serializer and every lane in reset
    pins_on = state.gate[xaui_quad_pkg::BIT_GATE];
    quad_now = (pins_on && state.pin_s2[xaui_quad_pkg::PIN_QUAD])
      || state.quad_rst[xaui_quad_pkg::BIT_QUAD_RST];
    serdes_now = quad_now || state.ser_rst[xaui_quad_pkg::BIT_SER_RST]
      || (pins_on && state.pin_s2[xaui_quad_pkg::PIN_SERDES]);
    tx_all_now = quad_now || (pins_on && state.pin_s2[xaui_quad_pkg::PIN_TX]);
    rx_all_now = quad_now || (pins_on && state.pin_s2[xaui_quad_pkg::PIN_RX]);

    // reset levels follow the bits for as long as they read one
    // per lane: the tx bit of lane i is 7-i, the rx bit is 3-i
    next_state.resets.quad = quad_now;
    next_state.resets.serdes = serdes_now;
    for (int i = 0; i < LANES; i++)
    begin
      next_state.resets.tx_lane[i] = tx_all_now
        || state.lane_rst[xaui_quad_pkg::BIT_TX_LANE_TOP - i];
      next_state.resets.rx_lane[i] = rx_all_now
        || state.lane_rst[xaui_quad_pkg::BIT_RX_LANE_TOP - i];
    end

    // register writes, ignored while a quad reset holds the defaults
    // a quad reset defaults its own bit too, so it lasts one cycle
    // when set by software and as long as the pin when set by pin;
    // software must write its settings again once it is over
    if (quad_now)
    begin
      next_state = with_defaults(next_state);
    end
    else if (reg_write)
    begin
      case (reg_addr)
        xaui_quad_pkg::OFS_RATE: next_state.rate = reg_wdata;
        xaui_quad_pkg::OFS_WIDTH: next_state.width = reg_wdata;
        xaui_quad_pkg::OFS_REFCLK: next_state.refclk = reg_wdata;
        xaui_quad_pkg::OFS_SYNC: next_state.sync = reg_wdata;
        xaui_quad_pkg::OFS_LANE_RST: next_state.lane_rst = reg_wdata;
        xaui_quad_pkg::OFS_SER_RST: next_state.ser_rst = reg_wdata;
        xaui_quad_pkg::OFS_GATE: next_state.gate = reg_wdata;
        xaui_quad_pkg::OFS_QUAD_RST: next_state.quad_rst = reg_wdata;
        default: next_state.rate = state.rate; // unmapped writes dropped
      endcase
    end

    // register reads answer one cycle later, unmapped reads zero
    // a read in the cycle of a write still returns the old value,
    // since the mux looks at the registered copy
    if (reg_read)
    begin
      next_state.rvalid = 1'b1;
      case (reg_addr)
        xaui_quad_pkg::OFS_RATE: next_state.rdata = state.rate;
        xaui_quad_pkg::OFS_WIDTH: next_state.rdata = state.width;
        xaui_quad_pkg::OFS_REFCLK: next_state.rdata = state.refclk;
        xaui_quad_pkg::OFS_SYNC: next_state.rdata = state.sync;
        xaui_quad_pkg::OFS_LANE_RST: next_state.rdata = state.lane_rst;
        xaui_quad_pkg::OFS_SER_RST: next_state.rdata = state.ser_rst;
        xaui_quad_pkg::OFS_GATE: next_state.rdata = state.gate;
        xaui_quad_pkg::OFS_QUAD_RST: next_state.rdata = state.quad_rst;
        default: next_state.rdata = 8'h00;
      endcase
    end

    // configuration levels towards the quad
    // the rate bits select full rate when zero, hence the inversion
    next_state.cfg.full_rate_tx = ~state.rate[xaui_quad_pkg::BIT_RATE_TX];
    next_state.cfg.full_rate_rx = ~state.rate[xaui_quad_pkg::BIT_RATE_RX];
    next_state.cfg.refclk_mode = {state.refclk[xaui_quad_pkg::BIT_REFCLK_HI],
      state.refclk[xaui_quad_pkg::BIT_REFCLK_LO]};
    next_state.cfg.tx_wide = state.width[xaui_quad_pkg::BIT_WIDE_TX];
    next_state.cfg.rx_wide = state.width[xaui_quad_pkg::BIT_WIDE_RX];
    next_state.cfg.tx_sync = state.sync[xaui_quad_pkg::BIT_TX_SYNC];

    // lane clocks and lane data pass two flops, a third keeps the pre-edge value
    // the data path has the same depth as the clock path, so the word
    // picked at a detected rise is the one held before that rise;
    // the fabric must hold each word steady for three core cycles
    next_state.clk_s1 = tx_clk;
    next_state.clk_s2 = state.clk_s1;
    next_state.clk_s3 = state.clk_s2;
    next_state.lane_s1 = tx_lane;
    next_state.lane_s2 = state.lane_s1;
    next_state.lane_s3 = state.lane_s2;
    rise = state.clk_s2 & ~state.clk_s3;
    wide = state.width[xaui_quad_pkg::BIT_WIDE_TX];

    // each lane samples on its own rising edge, or on lane 0 when synchronised
    // a lane in tx reset, alone or through the quad, shows zeros and no
    // valid; the serializer reset alone leaves the lanes running, as
    // it only holds the serial side
    for (int i = 0; i < LANES; i++)
    begin
      take[i] = state.sync[xaui_quad_pkg::BIT_TX_SYNC] ? rise[0] : rise[i];
      next_state.group[i].valid = 1'b0;
      if (state.resets.tx_lane[i] || state.resets.quad)
      begin
        next_state.group[i] = '0;
      end
      else if (take[i])
      begin
        // sampled byte and flag go to the state machine stage in order
        next_state.group[i].valid = 1'b1;
        next_state.group[i].kind_lo = classify(state.lane_s3[i].data[7:0],
          state.lane_s3[i].ctrl[0]);
        // wide mode carries both bytes, each qualified by its own flag
        if (wide)
        begin
          next_state.group[i].data = state.lane_s3[i].data;
          next_state.group[i].kind_hi = classify(state.lane_s3[i].data[15:8],
            state.lane_s3[i].ctrl[1]);
        end
        else
        begin
          // narrow mode: upper byte zero and no upper kind
          next_state.group[i].data = {8'h00, state.lane_s3[i].data[7:0]};
          next_state.group[i].kind_hi = xaui_quad_pkg::KIND_NONE;
        end
      end
    end

    // block reset returns everything to its power-up value
    // the serializer reset bit comes up set, so the serializer is held
    // until software clears it; the rate flags come up as full rate
    // because the rate bits come up as zero
    if (rst)
    begin
      next_state = '0;
      next_state = with_defaults(next_state);
      next_state.resets.serdes = 1'b1;
      next_state.cfg.full_rate_tx = 1'b1;
      next_state.cfg.full_rate_rx = 1'b1;
    end
  end

  // registers the whole state
  always_ff @(posedge clock)
  begin
    state <= next_state;
  end

  // outputs straight from the state flops
  // nothing combinational sits between a flop and a pin
  assign reg_rdata = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign resets = state.resets;
  assign config_out = state.cfg;
  assign tx_group = state.group;

endmodule : xaui_quad_reset_and_tx_port

`default_nettype wire

// ---- xgmii_fabric_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module xgmii_fabric_model (
  input wire logic run,
  input wire xaui_quad_pkg::lane_s [3:0] word,
  output logic [3:0] tx_clk,
  output xaui_quad_pkg::lane_s [3:0] tx_lane
);
  logic lane_clk = 1'b0;
  // 48 ns lane clock, unrelated in phase to the core clock
  always #24 if (run) lane_clk = ~lane_clk;
  // lanes share edges, as the tx sync setting expects
  assign tx_clk = {4{lane_clk}};
  // launch on the falling edge so data is steady around the sampling rise
  initial tx_lane = '0;
  always @(negedge lane_clk) tx_lane <= word;
endmodule : xgmii_fabric_model
`default_nettype wire
